// ===== common/rfs_map.vh
// Register offsets, field positions, reset values and limits of the receive filter.
`ifndef RFS_MAP_VH
`define RFS_MAP_VH

// ==========================================================================
// Register offsets
`define RFS_ADDR_W        5
`define RFS_OFF_CFG_STAT  5'h0C
`define RFS_OFF_ALIGN_TLY 5'h0D
`define RFS_OFF_CRC_TLY   5'h0E
`define RFS_OFF_MISS_TLY  5'h0F
`define RFS_OFF_STA_BASE  5'h10
`define RFS_OFF_HASH_BASE 5'h18

// ==========================================================================
// Receive configuration fields
`define RFS_CFG_W         6
`define RFS_CFG_SAVE_ERR  0
`define RFS_CFG_SHORT     1
`define RFS_CFG_ALL_ONES  2
`define RFS_CFG_GROUP     3
`define RFS_CFG_ANY_STA   4
`define RFS_CFG_CHECK     5
`define RFS_CFG_RESET     6'h00

// ==========================================================================
// Receive status fields
`define RFS_ST_INTACT     0
`define RFS_ST_CRC        1
`define RFS_ST_ALIGN      2
`define RFS_ST_OVERFLOW   3
`define RFS_ST_MISSED     4
`define RFS_ST_ADDR_TYPE  5
`define RFS_ST_OFF        6
`define RFS_ST_DEFER      7

// ==========================================================================
// Frame limits and checksum constants
`define RFS_MIN_BYTES     15'd64
`define RFS_RUNT_BYTES    15'd8
`define RFS_DA_BITS       15'd48
`define RFS_TALLY_MAX     8'hC0
`define RFS_CRC_POLY      32'h04C11DB7
`define RFS_CRC_INIT      32'hFFFFFFFF
`define RFS_CRC_RESIDUE   32'hC704DD7B
`define RFS_DRIBBLE_MAX   3'd6

`endif

// ===== rtl/rfs_rx_filter.v
// Receive acceptance filter and per-frame status logic of a 10 Mb/s MAC.
//
// What this block does
// RULE1 - Save-errored bit set accepts CRC or alignment errored frames; clear rejects.
// RULE2 - Frames under 64 bytes rejected unless runt bit set; runts need 8 bytes.
// RULE3 - All-ones destination accepted only while the all-ones bit is set.
// RULE4 - Group bit set checks group destinations against hash; clear skips them.
// RULE5 - Any-station bit accepts all station addresses; else must equal station address.
// RULE6 - Check-only mode still checks address, CRC, alignment but stores nothing.
// RULE7 - Check-only mode counts each address-recognised frame in the missed tally.
// RULE8 - All-ones and group acceptance combine as OR with own station match.
// RULE9 - Software sets bits 2 to 4 and all hash bits to receive everything.
// RULE10 - After a good frame the status byte is written with the frame.
// RULE11 - Saved errored frames get status after their last byte; rejected ones get none.
// RULE12 - Status clears when the next frame starts; reset loads zero, which holds until first reception.
// RULE13 - Intact bit set only when CRC, alignment, overflow and missed bits are zero.
// RULE14 - CRC bit set on mismatch and on alignment error; bumps CRC tally.
// RULE15 - Alignment bit set on odd ending with bad CRC; bumps alignment tally.
// RULE16 - Error bits encode none, CRC, or both; alignment alone never occurs.
// RULE17 - Receive FIFO overflow sets overflow bit and aborts the frame.
// RULE18 - Missed bit and tally on no buffer or check-only mode.
// RULE19 - Address type bit zero for station match, one for group or all-ones.
// RULE20 - Receiver-off bit set in check-only mode, cleared on leaving it.
// RULE21 - Deferring bit follows carrier sense or collision, including jabber collision.
// RULE22 - Writes at the shared offset load config; reads return status.
// RULE23 - Hash latches six CRC MSBs after destination, decodes one of 64.
// RULE24 - First destination bit zero means station address, one means group.
// RULE25 - Tallies saturate at 192 and clear when read.
// RULE26 - Reserved upper config bits have no effect on reception.
`timescale 1ns/1ps
`include "rfs_map.vh"

module rfs_rx_filter
(
	// Clock and reset
	input  wire       clk_i,
	input  wire       rst_i,
	// Register port
	input  wire [4:0] addr_i,
	input  wire [7:0] wr_data_i,
	input  wire       wr_i,
	input  wire       rd_i,
	output reg  [7:0] rd_data_o,
	// Serial link pins
	input  wire       rx_clk_i,
	input  wire       rx_data_i,
	input  wire       carrier_sense_in_i,
	input  wire       collision_i,
	// Buffer side
	input  wire       fifo_overflow_i,
	input  wire       buffer_avail_i,
	output reg  [7:0] byte_o,
	output reg        byte_valid_o,
	output reg  [7:0] status_byte_o,
	output reg        status_wr_o,
	output reg        frame_drop_o
);

	localparam ST_IDLE = 2'd0;
	localparam ST_HUNT = 2'd1;
	localparam ST_DATA = 2'd2;

	localparam [4:0] STA_BASE  = `RFS_OFF_STA_BASE;
	localparam [4:0] HASH_BASE = `RFS_OFF_HASH_BASE;
	localparam [1:0] STA_PAGE  = STA_BASE[4:3];
	localparam [1:0] HASH_PAGE = HASH_BASE[4:3];

	// ==========================================================================
	// Helper functions
	function [7:0] sat_inc;
		input [7:0] v;
		begin
			sat_inc = (v == `RFS_TALLY_MAX) ? v : v + 8'h01; // see RULE25
		end
	endfunction

	function [31:0] crc_step;
		input [31:0] c;
		input        d;
		begin
			crc_step = {c[30:0], 1'b0} ^ ((c[31] ^ d) ? `RFS_CRC_POLY : 32'h00000000);
		end
	endfunction

	function sta_sel;
		input [4:0] a;
		begin
			sta_sel = (a[4:3] == STA_PAGE) & (a[2:0] < 3'd6);
		end
	endfunction

	function hash_sel;
		input [4:0] a;
		begin
			hash_sel = (a[4:3] == HASH_PAGE);
		end
	endfunction

	function [7:0] tally_next;
		input [7:0] v;
		input       cnt;
		input       clr;
		begin
			if (cnt)
				tally_next = clr ? 8'h01 : sat_inc(v);
			else if (clr)
				tally_next = 8'h00;
			else
				tally_next = v;
		end
	endfunction

	function [7:0] status_word;
		input       defer;
		input       off;
		input [5:0] st;
		begin
			status_word = {defer, off, st};
		end
	endfunction

	// ==========================================================================
	// Synchronisers for the link pins
	reg  [1:0]  rxc_s_q;
	reg  [1:0]  rxd_s_q;
	reg  [1:0]  crs_s_q;
	reg  [1:0]  col_s_q;
	reg         rxc_prev_q;
	reg         crs_prev_q;
	wire        rx_edge = rxc_s_q[1] & ~rxc_prev_q;
	wire        rx_bit  = rxd_s_q[1];
	wire        crs_fall = crs_prev_q & ~crs_s_q[1];

	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rxc_s_q    <= 2'h0;
			rxd_s_q    <= 2'h0;
			crs_s_q    <= 2'h0;
			col_s_q    <= 2'h0;
			rxc_prev_q <= 1'b0;
			crs_prev_q <= 1'b0;
		end
		else
		begin
			rxc_s_q    <= {rxc_s_q[0], rx_clk_i};
			rxd_s_q    <= {rxd_s_q[0], rx_data_i};
			crs_s_q    <= {crs_s_q[0], carrier_sense_in_i};
			col_s_q    <= {col_s_q[0], collision_i};
			rxc_prev_q <= rxc_s_q[1];
			crs_prev_q <= crs_s_q[1];
		end
	end

	// ==========================================================================
	// Registers
	reg  [5:0]  cfg_q;
	reg  [47:0] sta_q;
	reg  [63:0] hash_q;
	reg  [7:0]  align_tly_q;
	reg  [7:0]  crc_tly_q;
	reg  [7:0]  miss_tly_q;
	reg  [5:0]  stat_q;

	// ==========================================================================
	// Frame receive state
	reg  [1:0]  state_q;
	reg  [14:0] bits_q;
	reg  [31:0] crc_q;
	reg         crc_ok_q;
	reg  [47:0] da_q;
	reg  [5:0]  hash_idx_q;
	reg  [7:0]  shift_q;
	reg         ovf_q;

	wire        check_only = cfg_q[`RFS_CFG_CHECK];
	wire [14:0] n_bytes    = {3'h0, bits_q[14:3]};
	wire [31:0] crc_next   = crc_step(crc_q, rx_bit);
	wire [14:0] bits_next  = bits_q + 15'd1;

	// Address recognition on the captured destination.
	wire        is_group  = da_q[0];                                   // see RULE24
	wire        is_ones   = &da_q;
	wire        sta_match = (da_q == sta_q);
	wire        hash_hit  = hash_q[hash_idx_q];                        // see RULE23
	wire        recog_phys  = ~is_group & (cfg_q[`RFS_CFG_ANY_STA] | sta_match); // see RULE5
	wire        recog_ones  = is_ones & cfg_q[`RFS_CFG_ALL_ONES];     // see RULE3
	wire        recog_group = is_group & ~is_ones & cfg_q[`RFS_CFG_GROUP] & hash_hit; // see RULE4
	wire        recognised  = recog_phys | recog_ones | recog_group;   // see RULE8

	// End-of-frame classification.
	wire        crc_err  = ~crc_ok_q;                                  // see RULE14
	wire        fae      = crc_err & (bits_q[2:0] != 3'd0);            // see RULE15
	wire        dribble_bad = (bits_q[2:0] >= `RFS_DRIBBLE_MAX) & ~crc_err;
	wire        err_any  = crc_err | fae | dribble_bad;
	wire        size_ok  = (n_bytes >= `RFS_MIN_BYTES) |
	                       (cfg_q[`RFS_CFG_SHORT] & (n_bytes >= `RFS_RUNT_BYTES)); // see RULE2
	wire        err_ok   = ~err_any | cfg_q[`RFS_CFG_SAVE_ERR];        // see RULE1
	wire        missed   = recognised & (check_only | ~buffer_avail_i); // see RULE18
	wire        crc_bit  = crc_err | dribble_bad;                      // see RULE16
	wire        intact   = ~crc_bit & ~fae & ~ovf_q & ~missed;         // see RULE13
	wire        store    = recognised & size_ok & err_ok & ~missed & ~ovf_q;
	wire [5:0]  stat_new;

	assign stat_new[`RFS_ST_INTACT]    = intact;
	assign stat_new[`RFS_ST_CRC]       = crc_bit;
	assign stat_new[`RFS_ST_ALIGN]     = fae;
	assign stat_new[`RFS_ST_OVERFLOW]  = ovf_q;
	assign stat_new[`RFS_ST_MISSED]    = missed;
	assign stat_new[`RFS_ST_ADDR_TYPE] = is_group;                     // see RULE19

	wire        frame_end = (state_q == ST_DATA) & crs_fall;
	wire        rd_align  = rd_i & (addr_i == `RFS_OFF_ALIGN_TLY);
	wire        rd_crc    = rd_i & (addr_i == `RFS_OFF_CRC_TLY);
	wire        rd_miss   = rd_i & (addr_i == `RFS_OFF_MISS_TLY);
	wire        cnt_align = frame_end & recognised & fae;
	wire        cnt_crc   = frame_end & recognised & crc_bit;
	wire        cnt_miss  = frame_end & missed;                        // see RULE7

	// ==========================================================================
	// Deserialiser and frame state machine
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_q      <= ST_IDLE;
			bits_q       <= 15'h0000;
			crc_q        <= `RFS_CRC_INIT;
			crc_ok_q     <= 1'b0;
			da_q         <= 48'h000000000000;
			hash_idx_q   <= 6'h00;
			shift_q      <= 8'h00;
			ovf_q        <= 1'b0;
			stat_q       <= 6'h00;
			byte_o       <= 8'h00;
			byte_valid_o <= 1'b0;
			status_wr_o  <= 1'b0;
			frame_drop_o <= 1'b0;
			status_byte_o <= 8'h00;
		end
		else
		begin
			byte_valid_o <= 1'b0;
			status_wr_o  <= 1'b0;
			frame_drop_o <= 1'b0;
			case (state_q)
				ST_IDLE:
				begin
					if (crs_s_q[1])
					begin
						state_q  <= ST_HUNT;
						shift_q  <= 8'h00;
						bits_q   <= 15'h0000;
						crc_q    <= `RFS_CRC_INIT;
						crc_ok_q <= 1'b0;
						ovf_q    <= 1'b0;
						stat_q   <= 6'h00;                         // see RULE12
					end
				end
				ST_HUNT:
				begin
					if (~crs_s_q[1])
						state_q <= ST_IDLE;
					else if (rx_edge)
					begin
						shift_q <= {rx_bit, shift_q[7:1]};
						if (rx_bit & shift_q[7])
							state_q <= ST_DATA;
					end
				end
				ST_DATA:
				begin
					if (crs_fall)
					begin
						state_q <= ST_IDLE;
						stat_q  <= stat_new;
						status_byte_o <= status_word(col_s_q[1] | crs_s_q[1], check_only, stat_new);
						if (store)
							status_wr_o <= 1'b1;                   // see RULE10 RULE11
						else
							frame_drop_o <= 1'b1;
					end
					else if (rx_edge)
					begin
						bits_q  <= bits_next;
						crc_q   <= crc_next;
						shift_q <= {rx_bit, shift_q[7:1]};
						if (bits_q < `RFS_DA_BITS)
							da_q <= {rx_bit, da_q[47:1]};
						if (bits_next == `RFS_DA_BITS)
							hash_idx_q <= crc_next[31:26];             // see RULE23
						if (bits_next[2:0] == 3'd0)
						begin
							crc_ok_q <= (crc_next == `RFS_CRC_RESIDUE);
							byte_o   <= {rx_bit, shift_q[7:1]};
							byte_valid_o <= ~check_only & ~ovf_q & ~fifo_overflow_i; // see RULE6
						end
					end
					if (fifo_overflow_i)
						ovf_q <= 1'b1;                             // see RULE17
				end
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// ==========================================================================
	// Register writes and tallies
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cfg_q       <= `RFS_CFG_RESET;
			sta_q       <= 48'h000000000000;
			hash_q      <= 64'h0000000000000000;
			align_tly_q <= 8'h00;
			crc_tly_q   <= 8'h00;
			miss_tly_q  <= 8'h00;
		end
		else
		begin
			if (wr_i & (addr_i == `RFS_OFF_CFG_STAT))
				cfg_q <= wr_data_i[5:0];                           // see RULE22 RULE26
			if (wr_i & sta_sel(addr_i))
				sta_q[addr_i[2:0]*8 +: 8] <= wr_data_i;
			if (wr_i & hash_sel(addr_i))
				hash_q[addr_i[2:0]*8 +: 8] <= wr_data_i;
			align_tly_q <= tally_next(align_tly_q, cnt_align, rd_align); // see RULE15 RULE25
			crc_tly_q   <= tally_next(crc_tly_q, cnt_crc, rd_crc);       // see RULE14
			miss_tly_q  <= tally_next(miss_tly_q, cnt_miss, rd_miss);    // see RULE18
		end
	end

	// ==========================================================================
	// Register reads
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			rd_data_o <= 8'h00;
		else if (rd_i)
		begin
			case (addr_i)
				`RFS_OFF_CFG_STAT:
					rd_data_o <= status_word(col_s_q[1] | crs_s_q[1], check_only, stat_q); // see RULE20 RULE21 RULE22
				`RFS_OFF_ALIGN_TLY:
					rd_data_o <= align_tly_q;
				`RFS_OFF_CRC_TLY:
					rd_data_o <= crc_tly_q;
				`RFS_OFF_MISS_TLY:
					rd_data_o <= miss_tly_q;
				default:
				begin
					if (sta_sel(addr_i))
						rd_data_o <= sta_q[addr_i[2:0]*8 +: 8];
					else if (hash_sel(addr_i))
						rd_data_o <= hash_q[addr_i[2:0]*8 +: 8];
					else
						rd_data_o <= 8'h00;
				end
			endcase
		end
		else
			rd_data_o <= 8'h00;
	end

endmodule // rfs_rx_filter

// ===== verif/rfs_rx_filter_asserts.sv
// Port assertions for the receive filter.
`timescale 1ns/1ps
module rfs_rx_filter_asserts
(
	// Clock and reset
	input logic       clk_i,
	input logic       rst_i,
	// Register port
	input logic [4:0] addr_i,
	input logic       rd_i,
	input logic [7:0] rd_data_o,
	// Link and buffer side
	input logic       carrier_sense_in_i,
	input logic       collision_i,
	input logic [7:0] status_byte_o,
	input logic       status_wr_o,
	input logic       frame_drop_o
);
	logic [4:0] col_q;
	wire        end_w;
	assign end_w = status_wr_o | frame_drop_o;
	always @(posedge clk_i)
		col_q <= {col_q[3:0], collision_i};
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ==========
	// Port relations
	a_end_excl: assert property (!(status_wr_o && frame_drop_o))
		else $error("both end pulses");
	a_rd_idle: assert property (!$past(rd_i) |-> rd_data_o == 8'h00)
		else $error("stray read data");
	a_intact_only: assert property (
		end_w && status_byte_o[0] |-> status_byte_o[4:1] == 4'h0)
		else $error("intact with errors");
	a_align_crc: assert property (end_w && status_byte_o[2] |-> status_byte_o[1])
		else $error("lone alignment bit");
	a_ovf_abort: assert property (end_w && status_byte_o[3] |-> frame_drop_o)
		else $error("overflow stored");
	a_miss_drop: assert property (status_wr_o |-> !status_byte_o[4])
		else $error("missed frame stored");
	a_tally_cap: assert property (
		rd_i && addr_i inside {5'h0D, 5'h0E, 5'h0F} |=> rd_data_o <= 8'hC0)
		else $error("tally over limit");
	a_end_bound: assert property ($fell(carrier_sense_in_i) |-> ##[1:8] end_w)
		else $error("no end pulse");
	a_defer_live: assert property (
		rd_i && addr_i == 5'h0C && col_q == 5'h1F |=> rd_data_o[7])
		else $error("deferring bit low");
	a_stat_holds: assert property (!end_w |-> $stable(status_byte_o[5:0]))
		else $error("status byte moved");
endmodule // rfs_rx_filter_asserts
bind rfs_rx_filter rfs_rx_filter_asserts i_chk (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
	.rd_i(rd_i), .rd_data_o(rd_data_o), .carrier_sense_in_i(carrier_sense_in_i),
	.collision_i(collision_i), .status_byte_o(status_byte_o), .status_wr_o(status_wr_o),
	.frame_drop_o(frame_drop_o));

// ===== verif/rfs_link_model.sv
// Serial sender standing on the far side of the link.
`timescale 1ns/1ps
module rfs_link_model
(
	// Link pins
	output logic rx_clk_o,
	output logic rx_data_o,
	output logic carrier_o
);
	logic [7:0] fb [0:127];
	initial
	begin
		rx_clk_o = 1'b0;
		rx_data_o = 1'b0;
		carrier_o = 1'b0;
	end
	function automatic logic [31:0] crc_bit(input logic [31:0] c, input logic d);
		return {c[30:0], 1'b0} ^ ((c[31] ^ d) ? 32'h04C11DB7 : 32'h00000000);
	endfunction
	task automatic put(input logic b);
		rx_data_o = b;
		#100 rx_clk_o = 1'b1;
		#100 rx_clk_o = 1'b0;
	endtask
	task automatic send(input int n, input int drib, input logic bad);
		logic [31:0] c;
		c = 32'hFFFFFFFF;
		carrier_o = 1'b1;
		for (int i = 0; i < 16; i++)
			put(i == 15 || !i[0]);
		for (int i = 0; i < (n - 4) * 8; i++)
		begin
			c = crc_bit(c, fb[i / 8][i % 8]);
			put(fb[i / 8][i % 8]);
		end
		c = ~c ^ {31'h0, bad};
		for (int i = 31; i >= 0; i--)
			put(c[i]);
		for (int i = 0; i < drib; i++)
			put(i[0]);
		carrier_o = 1'b0;
		rx_data_o = ~rx_data_o;
	endtask
endmodule // rfs_link_model

// ===== verif/tb_top.sv
// Self-checking bench for the receive filter.
`timescale 1ns/1ps
module tb_top;
	logic       clk_i = 1'b0;
	logic       rst_i = 1'b1;
	logic [4:0] addr_i = 5'h00;
	logic [7:0] wr_data_i = 8'h00;
	logic       wr_i = 1'b0;
	logic       rd_i = 1'b0;
	logic       collision_i = 1'b0;
	logic       fifo_overflow_i = 1'b0;
	logic       buffer_avail_i = 1'b1;
	logic       rx_clk_i, rx_data_i, carrier_sense_in_i, byte_valid_o, status_wr_o, frame_drop_o;
	logic [7:0] rd_data_o, byte_o, status_byte_o;
	int         err_count = 0;
	int         num_checks = 0;
	int         nbytes = 0;
	logic [7:0] rx_mem [0:127];
	always #12.5 clk_i = ~clk_i;
	always @(posedge clk_i) nbytes <= nbytes + int'(byte_valid_o);
	always @(posedge clk_i) if (byte_valid_o) rx_mem[nbytes[6:0]] <= byte_o;
	rfs_rx_filter i_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
		.wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .rx_clk_i(rx_clk_i), .rx_data_i(rx_data_i),
		.carrier_sense_in_i(carrier_sense_in_i), .collision_i(collision_i),
		.fifo_overflow_i(fifo_overflow_i), .buffer_avail_i(buffer_avail_i), .byte_o(byte_o),
		.byte_valid_o(byte_valid_o), .status_byte_o(status_byte_o), .status_wr_o(status_wr_o),
		.frame_drop_o(frame_drop_o));
	rfs_link_model i_link (.rx_clk_o(rx_clk_i), .rx_data_o(rx_data_i),
		.carrier_o(carrier_sense_in_i));
	// ==========
	// Shared tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
			err_count++;
		if (got !== exp)
			$display("FAIL t=%0t got %h exp %h", $time, got, exp);
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		addr_i <= a;
		wr_data_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rdc(input logic [4:0] a, input logic [7:0] e);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 chk(rd_data_o, e);
		@(posedge clk_i);
	endtask
	function automatic logic [7:0] dab(input int da, input int k);
		if (da == 2)
			return 8'hFF;
		if (k == 0)
			return (da == 0) ? 8'h02 : (da == 1) ? 8'h04 : 8'h01;
		return 8'h10 + 8'(k);
	endfunction
	task automatic frame(input int da, n, drib, e, input logic ok, input logic [7:0] m, st,
		input int nb);
		int b0;
		int w;
		for (int k = 0; k < 128; k++)
			i_link.fb[k] = (k < 6) ? dab(da, k) : 8'(k);
		b0 = nbytes;
		w = 0;
		fork
			i_link.send(n, drib, e == 1);
			if (e == 2)
			begin
				repeat (500) @(posedge clk_i);
				fifo_overflow_i <= 1'b1;
				@(posedge clk_i);
				fifo_overflow_i <= 1'b0;
			end
		join
		do
		begin
			@(posedge clk_i);
			#1 w++;
		end
		while (status_wr_o !== 1'b1 && frame_drop_o !== 1'b1 && w < 40);
		chk({status_wr_o, frame_drop_o, status_byte_o[5:0] & m[5:0]}, {ok, !ok, st[5:0]});
		if (nb >= 0)
			chk(8'(nbytes - b0), 8'(nb));
		if (nb > 0)
			chk(rx_mem[7'(b0)], dab(da, 0));
		if (nb > 6)
			chk(rx_mem[7'(b0 + 6)], 8'h06);
		@(posedge clk_i);
	endtask
	// ==========
	// Scenarios
	task automatic t_addr;
		logic [31:0] c;
		logic [7:0]  b;
		c = 32'hFFFFFFFF;
		for (int a = 13; a < 16; a++)
			rdc(5'(a), 8'h00);
		rdc(5'h00, 8'h00);
		for (int k = 0; k < 6; k++)
			wr(5'h10 + 5'(k), dab(0, k));
		wr(5'h0C, 8'hC0);
		frame(0, 64, 0, 0, 1, 8'h3F, 8'h01, 64);
		frame(2, 64, 0, 0, 0, 8'h00, 8'h00, -1);
		wr(5'h0C, 8'h04);
		frame(2, 64, 0, 0, 1, 8'h3F, 8'h21, -1);
		wr(5'h0C, 8'h18);
		frame(1, 64, 0, 0, 1, 8'h3F, 8'h01, -1);
		for (int i = 0; i < 48; i++)
		begin
			b = dab(3, i / 8);
			c = i_link.crc_bit(c, b[i % 8]);
		end
		wr(5'h18 + 5'(c[31:29]), 8'h01 << c[28:26]);
		frame(3, 64, 0, 0, 1, 8'h3F, 8'h21, -1);
		wr(5'h18 + 5'(c[31:29]), 8'h00);
		frame(3, 64, 0, 0, 0, 8'h00, 8'h00, -1);
		for (int k = 0; k < 8; k++)
			wr(5'h18 + 5'(k), 8'hFF);
		wr(5'h0C, 8'h1C);
		frame(3, 64, 0, 0, 1, 8'h3F, 8'h21, -1);
		$display("address test done");
	endtask
	task automatic t_err;
		wr(5'h0C, 8'h00);
		frame(0, 60, 0, 0, 0, 8'h00, 8'h00, -1);
		frame(0, 64, 0, 1, 0, 8'h3F, 8'h02, -1);
		wr(5'h0C, 8'h03);
		frame(0, 60, 0, 0, 1, 8'h3F, 8'h01, 60);
		frame(0, 64, 3, 1, 1, 8'h3F, 8'h06, -1);
		frame(0, 64, 3, 0, 1, 8'h3F, 8'h01, -1);
		rdc(5'h0E, 8'h02);
		rdc(5'h0D, 8'h01);
		rdc(5'h0E, 8'h00);
		$display("error test done");
	endtask
	task automatic t_mon;
		wr(5'h0C, 8'h20);
		frame(0, 64, 0, 0, 0, 8'h3F, 8'h10, 0);
		rdc(5'h0C, 8'h50);
		rdc(5'h0F, 8'h01);
		wr(5'h0C, 8'h00);
		buffer_avail_i <= 1'b0;
		frame(0, 64, 0, 0, 0, 8'h3F, 8'h10, -1);
		buffer_avail_i <= 1'b1;
		rdc(5'h0C, 8'h10);
		rdc(5'h0F, 8'h01);
		collision_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		rdc(5'h0C, 8'h90);
		collision_i <= 1'b0;
		repeat (8) @(posedge clk_i);
		rdc(5'h0C, 8'h10);
		frame(0, 64, 0, 2, 0, 8'h09, 8'h08, -1);
		$display("monitor test done");
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_addr();
		t_err();
		t_mon();
		test_done();
	end
	initial
	begin
		repeat (90000) @(posedge clk_i);
		err_count++;
		test_done();
	end
endmodule // tb_top
